// *** bench/sapp_asserts.sv ***
// Checker of the converter control port.
`timescale 1ns/1ps
module sapp_asserts (
  // Clock and reset.
  input wire logic        mclk,
  input wire logic        reset_n,
  // Host pins.
  input wire logic        cs_n,
  input wire logic        read_conv,
  input wire logic        busy_n,
  input wire logic [11:0] result_bus_o,
  input wire logic [11:0] result_bus_oe,
  // Core side.
  input wire logic        smp_ready,
  input wire logic        hold_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // Four cycles cover the pin sync and the output register.
  chk_cs_off: assert property (cs_n [*4] |-> result_bus_oe == '0)
    else $error("bus driven while deselected");
  chk_rc_off: assert property (!read_conv [*4] |-> result_bus_oe == '0)
    else $error("bus driven while converting");
  chk_busy_off: assert property (!busy_n |-> result_bus_oe == '0)
    else $error("bus driven while busy");
  chk_oe_same: assert property (result_bus_oe == '0 || result_bus_oe == '1)
    else $error("bus enables split");
  chk_rise_data: assert property ($rose(busy_n) |-> $stable(result_bus_o))
    else $error("data moved at busy rise");
  chk_hold_res: assert property (busy_n && $past(busy_n) |->
    $stable(result_bus_o))
    else $error("result moved while idle");
  chk_start_why: assert property ($fell(busy_n) |->
    hold_q && $past(!cs_n && !read_conv, 3))
    else $error("conversion without request");
  chk_busy_span: assert property ($fell(busy_n) |-> ##[40:70] $rose(busy_n))
    else $error("busy span out of range");
  chk_oe_on: assert property ((busy_n && !cs_n && read_conv) [*4] |->
    result_bus_oe == '1)
    else $error("bus not enabled for read");
  // Main scenarios.
  cov_start: cover property ($fell(busy_n));
  cov_read: cover property ($rose(result_bus_oe[0]));
  cov_full: cover property (!smp_ready);
endmodule

// *** bench/sapp_host_model.sv ***
// Host model driving select and read/convert.
`timescale 1ns/1ps
module sapp_host_model (
  // Clock.
  input  wire logic        mclk,
  // Device pins.
  output logic             cs_n,
  output logic             read_conv,
  input  wire logic        busy_n,
  input  wire logic [11:0] result_bus_o,
  input  wire logic [11:0] result_bus_oe,
  // Bus level as the host sees it.
  output logic [11:0]      bus
);
  realtime t_last;
  initial begin
    cs_n = 1'b1;
    read_conv = 1'b1;
    t_last = 0.0;
  end
  ////////////////////////////////////////
  // host quiet: the host never drives the bus; a released bit
  // shows the inverse so stale data can never pass a compare.
  always_comb
    for (int i = 0; i < 12; i++)
      bus[i] = result_bus_oe[i] ? result_bus_o[i] : ~result_bus_o[i];
  // Pins change just after a rising edge.
  task automatic pins(input logic c, input logic r);
    @(posedge mclk);
    cs_n <= c;
    read_conv <= r;
  endtask
  // spacing, setup, width: other input low one cycle ahead.
  task automatic start(input logic by_cs);
    while ($realtime - t_last < 1260.0) @(posedge mclk);
    pins(by_cs, !by_cs);
    pins(1'b0, 1'b0);
    t_last = $realtime;
  endtask
endmodule

// *** bench/tb_top.sv ***
// Testbench for the converter control port.
`timescale 1ns/1ps
module tb_top;
  import sapp_pkg::*;
  logic         mclk, reset_n, cs_n, read_conv, busy_n, hold_q;
  logic         smp_valid, smp_ready, clk_en;
  logic [11:0]  result_bus_o, result_bus_oe, bus;
  sapp_sample_s smp_data;
  int           num_errors, comparisons;
  logic [11:0]  q[$];
  logic [11:0]  codes [4] = '{12'h7ff, 12'h000, 12'hfff, 12'h800};
  sapp_core #(.FIFO_DEPTH(16)) u_dut (.mclk, .reset_n, .clk_en,
    .cs_n, .read_conv, .busy_n, .result_bus_o, .result_bus_oe,
    .smp_data, .smp_valid, .smp_ready, .hold_q);
  sapp_host_model u_host (.mclk, .cs_n, .read_conv, .busy_n,
    .result_bus_o, .result_bus_oe, .bus);
  always #10 mclk = ~mclk;
  ////////////////////////////////////////
  // Shared compare, wait and verdict helpers.
  task automatic chk(string nm, logic [11:0] exp, logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask
  // Bounded so a stuck busy cannot hang the run.
  task automatic wait_busy(logic v);
    for (int k = 0; k < 100 && busy_n !== v; k++) @(negedge mclk);
    chk("busy_n", {11'h0, v}, {11'h0, busy_n});
  endtask
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [11:0] w(int i);
    return i < 4 ? codes[i] : i[11:0] * 12'h111;
  endfunction
  ////////////////////////////////////////
  // Scenarios.
  task automatic t_fill;
    int n;
    logic r;
    n = 0;
    @(posedge mclk);
    smp_valid <= 1'b1;
    smp_data.code <= w(0);
    for (int k = 0; k < 20; k++) begin
      @(negedge mclk);
      r = smp_ready;
      @(posedge mclk);
      if (!r) break;
      q.push_back(w(n));
      n++;
      smp_data.code <= w(n);
    end
    smp_valid <= 1'b0;
    chk("fifo words", 12'h010, n[11:0]);
    $display("test fill done");
  endtask
  task automatic t_rc;
    logic [11:0] e;
    e = q.pop_front();
    u_host.pins(1'b0, 1'b1);
    cyc(5);
    chk("idle read", 12'h000, bus);
    u_host.start(1'b0);
    wait_busy(1'b0);
    chk("oe at start", 12'h000, result_bus_oe);
    u_host.pins(1'b0, 1'b1);
    cyc(5);
    chk("oe in conversion", 12'h000, result_bus_oe);
    wait_busy(1'b1);
    chk("latched", e, result_bus_o);
    cyc(2);
    chk("read", e, bus);
    $display("test rc done");
  endtask
  task automatic t_cs;
    logic [11:0] e;
    e = q.pop_front();
    u_host.start(1'b1);
    wait_busy(1'b0);
    wait_busy(1'b1);
    cyc(3);
    chk("oe convert low", 12'h000, result_bus_oe);
    u_host.pins(1'b1, 1'b1);
    cyc(5);
    chk("oe deselected", 12'h000, result_bus_oe);
    u_host.pins(1'b0, 1'b1);
    cyc(5);
    chk("select read", e, bus);
    cyc(20);
    chk("reread", e, bus);
    $display("test cs done");
  endtask
  task automatic t_ignore;
    logic [11:0] e;
    e = q.pop_front();
    u_host.start(1'b0);
    wait_busy(1'b0);
    u_host.pins(1'b0, 1'b1);
    u_host.pins(1'b0, 1'b0);
    u_host.pins(1'b0, 1'b0);
    u_host.pins(1'b0, 1'b1);
    // Freeze twelve edges; the conversion must stretch by as much.
    @(posedge mclk);
    clk_en <= 1'b0;
    cyc(12);
    @(posedge mclk);
    clk_en <= 1'b1;
    cyc(38);
    chk("frozen busy", 12'h000, {11'h0, busy_n});
    wait_busy(1'b1);
    cyc(70);
    chk("no restart", 12'h001, {11'h0, busy_n});
    chk("result kept", e, bus);
    $display("test ignore done");
  endtask
  // Select stays low and read/convert alone runs the part dry.
  task automatic t_drain;
    logic [11:0] e;
    while (q.size() > 0) begin
      e = q.pop_front();
      u_host.start(1'b0);
      wait_busy(1'b0);
      u_host.pins(1'b0, 1'b1);
      wait_busy(1'b1);
      cyc(2);
      chk("drain read", e, bus);
    end
    chk("fifo open", 12'h001, {11'h0, smp_ready});
    $display("test drain done");
  endtask
  ////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    smp_valid = 1'b0;
    clk_en = 1'b1;
    smp_data = '0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    chk("reset busy", 12'h001, {11'h0, busy_n});
    chk("reset result", 12'h000, result_bus_o);
    t_fill();
    t_rc();
    t_cs();
    t_ignore();
    t_drain();
    results();
  end
  // Watchdog well beyond sixteen conversions.
  initial begin
    #100000;
    num_errors++;
    results();
  end
endmodule
bind sapp_core sapp_asserts u_chk (.mclk, .reset_n, .cs_n, .read_conv,
  .busy_n, .result_bus_o, .result_bus_oe, .smp_ready, .hold_q);

// *** src/sapp_core.sv ***
// Converter control and parallel readout port, device side.
`timescale 1ns/1ps
module sapp_core
  import sapp_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // Clock, reset and freeze.
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  input  wire logic                 clk_en,
  // Host control pins.
  input  wire logic                 cs_n,
  input  wire logic                 read_conv,
  output logic                      busy_n,
  // Result bus pins.
  output logic [sapp_pkg::RES_W-1:0] result_bus_o,
  output logic [sapp_pkg::RES_W-1:0] result_bus_oe,
  // Sample stream from the converter core.
  input  wire sapp_pkg::sapp_sample_s smp_data,
  input  wire logic                 smp_valid,
  output logic                      smp_ready,
  // Conversion strobe towards the sample/hold.
  output logic                      hold_q
);
  import sapp_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and request qualification.

  logic       cs_n_m_q, cs_n_s_q;
  logic       rc_m_q, rc_s_q;
  logic [CNT_W-1:0] low_cnt_q;
  logic       conv_req;
  logic       rd_en;

  // Two-flop synchronisers; only the second stage is read downstream.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cs_n_m_q <= 1'b1;
      cs_n_s_q <= 1'b1;
      rc_m_q   <= 1'b1;
      rc_s_q   <= 1'b1;
    end else if (clk_en) begin
      cs_n_m_q <= cs_n;
      cs_n_s_q <= cs_n_m_q;
      rc_m_q   <= read_conv;
      rc_s_q   <= rc_m_q;
    end
  end

  // level-combined controls
  // The two lines are ANDed as levels (both low), so either order of falling works.
  assign conv_req = !cs_n_s_q && !rc_s_q;

  // minimum pulse width
  // Count how long both lines stay low; a glitch shorter than the
  // minimum width never starts a conversion.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt_q <= '0;
    end else if (clk_en) begin
      if (!conv_req) begin
        low_cnt_q <= '0;
      end else if (low_cnt_q < CNT_W'(CONV_PULSE_CYC)) begin
        low_cnt_q <= low_cnt_q + 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Conversion sequencer.

  sapp_state_e      state_q;
  logic [CNT_W-1:0] conv_cnt_q;
  logic [RES_W-1:0] result_q;
  logic             armed_q;
  logic             start;
  logic             f_valid;
  logic             f_ready;
  sapp_sample_s     f_data;

  // A request must be released before another one can start, so a
  // line held low does not retrigger back to back conversions.
  // requests ignored while busy
  assign start = (state_q == SAPP_IDLE) && armed_q &&
                 (low_cnt_q == CNT_W'(CONV_PULSE_CYC - 1)) && conv_req;

  // Re-arm once the request level goes away outside a conversion.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      armed_q <= 1'b1;
    end else if (clk_en) begin
      if (start) begin
        armed_q <= 1'b0;
      end else if (!conv_req && state_q == SAPP_IDLE) begin
        armed_q <= 1'b1;
      end
    end
  end

  // data valid deadline
  // The result is loaded no later than the data-valid limit; the
  // sample stream is popped at that moment and must be ready.
  // The limit counts from the pin edge, so the two sync stages, the
  // pulse qualification and the start edge are taken off the count.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q    <= SAPP_IDLE;
      conv_cnt_q <= '0;
    end else if (clk_en) begin
      unique case (state_q)
        SAPP_IDLE: begin
          conv_cnt_q <= '0;
          if (start) begin
            state_q <= SAPP_CONV;
          end
        end
        SAPP_CONV: begin
          conv_cnt_q <= conv_cnt_q + 1'b1;
          if (conv_cnt_q >= CNT_W'(DATA_VALID_CYC - 5) && f_valid) begin
            state_q    <= SAPP_DONE;
            conv_cnt_q <= '0;
          end
        end
        SAPP_DONE: begin
          conv_cnt_q <= conv_cnt_q + 1'b1;
          if (conv_cnt_q >= CNT_W'(BUSY_DLY_CYC - 1)) begin
            state_q <= SAPP_IDLE;
          end
        end
        default: begin
          state_q <= SAPP_IDLE;
        end
      endcase
    end
  end

  assign f_ready = clk_en && (state_q == SAPP_CONV) &&
                   (conv_cnt_q >= CNT_W'(DATA_VALID_CYC - 5));

  // twelve-bit two's complement word
  // The core delivers codes already in two's complement form, so
  // scale codes pass through unchanged.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      result_q <= RESULT_RST;
    end else if (f_ready && f_valid) begin
      result_q <= f_data.code;
    end
  end

  // Sample hold is asserted for the whole conversion.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hold_q <= 1'b0;
    end else if (clk_en) begin
      hold_q <= start || (state_q == SAPP_CONV);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      busy_n <= 1'b1;
    end else if (clk_en) begin
      if (start) begin
        busy_n <= 1'b0;
      end else if (state_q == SAPP_DONE &&
                   conv_cnt_q >= CNT_W'(BUSY_DLY_CYC - 1)) begin
        busy_n <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Result bus drivers.

  // select tied low works
  // Drive only when selected, reading, and idle; the enable follows
  // the busy flop so data is already stable when busy rises.
  assign rd_en = !cs_n_s_q && rc_s_q && (state_q == SAPP_IDLE) && !start;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      result_bus_oe <= '0;
      result_bus_o  <= RESULT_RST;
    end else if (clk_en) begin
      result_bus_oe <= {RES_W{rd_en}};
      result_bus_o  <= (state_q == SAPP_DONE || f_ready) ?
                       (f_valid && f_ready ? f_data.code : result_q)
                       : result_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sample buffer between core and output register.

  sapp_fifo #(
    .WIDTH (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .in_data   (smp_data.code),
    .in_valid  (smp_valid),
    .in_ready  (smp_ready),
    .out_data  (f_data.code),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );
endmodule

// *** src/sapp_fifo.sv ***
// Sample FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module sapp_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  // Write side.
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Read side.
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit.
  assign in_ready  = !((wr_q[AW] != rd_q[AW]) &&
                       (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = clk_en && in_valid && in_ready;
  assign pop       = clk_en && out_valid && out_ready;

  // Storage array is written only, never reset.
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// *** src/sapp_pkg.sv ***
// Package for the parallel-output converter control block.
package sapp_pkg;

  // Result word width and key output codes.
  localparam int          RES_W        = 12;
  localparam logic [11:0] CODE_POS_FS  = 12'h7ff;
  localparam logic [11:0] CODE_MID     = 12'h000;
  localparam logic [11:0] CODE_NEG_1   = 12'hfff;
  localparam logic [11:0] CODE_NEG_FS  = 12'h800;
  localparam logic [11:0] RESULT_RST   = 12'h000;

  // Clock rate and timing figures.
  localparam int CLK_PERIOD_PS   = 20000;
  localparam int T_CONV_PULSE_PS = 40000;
  localparam int T_DATA_VALID_PS = 1095000;
  localparam int T_BUSY_DLY_PS   = 20000;
  localparam int T_SETUP_PS      = 10000;
  // Least times round up, longest times round down, at least one cycle.
  localparam int CONV_PULSE_CYC =
    (T_CONV_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DATA_VALID_CYC = T_DATA_VALID_PS / CLK_PERIOD_PS;
  localparam int BUSY_DLY_CYC   =
    (T_BUSY_DLY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W          = 8;

  // Conversion sequencer states.
  typedef enum logic [1:0] {
    SAPP_IDLE = 2'b00,
    SAPP_CONV = 2'b01,
    SAPP_DONE = 2'b10
  } sapp_state_e;

  // Sample word travels as one carrier; its valid flag is a separate signal.
  typedef struct packed {
    logic [11:0] code;
  } sapp_sample_s;

endpackage
